// [core/hdc_params.svh]
`ifndef HDC_PARAMS_SVH
`define HDC_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses and write key
// ----------------------------------------------------------------
`define HDC_ADDR_CTRL     32'hE000EDF0
`define HDC_ADDR_EVT      32'hE000ED30
`define HDC_KEY           16'hA05F
`define HDC_KEY_HI        31
`define HDC_KEY_LO        16

// ----------------------------------------------------------------
// debug event status bits
// ----------------------------------------------------------------
`define HDC_EVT_EXT       4
`define HDC_EVT_VC        3
`define HDC_EVT_WP        2
`define HDC_EVT_BP        1
`define HDC_EVT_HS        0
`define HDC_EVT_W         5
`define HDC_EVT_RST       5'h00

// ----------------------------------------------------------------
// halting control/status bits
// ----------------------------------------------------------------
`define HDC_ST_RESTART    26
`define HDC_ST_RESET      25
`define HDC_ST_RETIRE     24
`define HDC_ST_SDE        20
`define HDC_ST_LOCKUP     19
`define HDC_ST_SLEEP      18
`define HDC_ST_HALT       17
`define HDC_ST_RDY        16
`define HDC_C_SNAP        5
`define HDC_C_MASK        3
`define HDC_C_STEP        2
`define HDC_C_HALT        1
`define HDC_C_EN          0

// ----------------------------------------------------------------
// read-clear sticky bank: index 2 restart, 1 reset, 0 retire
// ----------------------------------------------------------------
`define HDC_STK_W         3
`define HDC_STK_RESTART   2
`define HDC_STK_RESET     1
`define HDC_STK_RETIRE    0
`define HDC_STK_RST       3'h2
`define HDC_RDY_RST       1'h1

`endif

// [core/hdc_pkg.sv]
package hdc_pkg;

  // register access request, one per cycle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic        debugger;
    logic        word;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hdc_req_t;

  // registered answer
  typedef struct packed {
    logic        ack;
    logic        fault;
    logic [31:0] rdata;
  } hdc_rsp_t;

  // core state levels
  typedef struct packed {
    logic halted;
    logic in_secure;
    logic sec_allowed;
    logic halt_allowed;
    logic lockup;
    logic sleeping;
  } hdc_core_t;

  // one-cycle debug event pulses
  typedef struct packed {
    logic ext;
    logic vector_catch_flag;
    logic watch;
    logic breakpoint_flag;
    logic halt_step;
  } hdc_evt_t;

  // effective controls towards the core
  typedef struct packed {
    logic halt;
    logic step;
    logic mask;
    logic mask_secure;
    logic snap;
    logic restart;
  } hdc_ctrl_t;

endpackage

// [core/hdc_sticky.sv]
`timescale 1ns/1ns
// sticky bit bank: hardware set wins over any clear in the same cycle
module hdc_sticky #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  // set and clear strobes
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  // flag values
  output logic      [W-1:0] o_q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // set first so a coincident clear cannot lose an event
      always_comb begin
        q_next[gi] = i_set[gi] | (q_reg[gi] & ~i_clr[gi]);
      end
      always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
          q_reg[gi] <= RST[gi];
        end else begin
          q_reg[gi] <= q_next[gi];
        end
      end
    end
  endgenerate

  assign o_q = q_reg;
endmodule // hdc_sticky

// [core/hdc_top.sv]
`timescale 1ns/1ns
`include "hdc_params.svh"

module hdc_top #(
  parameter bit HAS_HALT_DEBUG = 1'b1,  // vector catch present
  parameter bit HAS_WATCH_UNIT = 1'b1   // watchpoint unit present
) (
  // clock and reset (reset is the cold reset)
  input  wire logic            i_clock,
  input  wire logic            i_rst_b,
  // register access port
  input  wire hdc_pkg::hdc_req_t i_req,
  output hdc_pkg::hdc_rsp_t    o_rsp,
  // core state and events
  input  wire hdc_pkg::hdc_core_t i_core,
  input  wire hdc_pkg::hdc_evt_t  i_evt,
  input  wire logic            i_warm_rst,
  input  wire logic            i_dbg_pend,
  input  wire logic            i_ext_restart,
  input  wire logic            i_retire,
  input  wire logic            i_xfer_sel_wr,
  input  wire logic            i_xfer_done,
  // controls to the core
  output hdc_pkg::hdc_ctrl_t   o_ctrl
);
  import hdc_pkg::*;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic hit_ctrl;   // address is the halting control register
  logic hit_evt;    // address is the event status register
  logic acc_ok;     // privileged access to a mapped register
  logic wr_ok;      // full-word privileged write
  logic key_ok;     // upper half carries the write key
  logic ctrl_wr;    // accepted control write
  logic evt_wr;     // accepted event status write
  logic ctrl_rd;    // read of the control register

  always_comb begin
    hit_ctrl = i_req.addr == `HDC_ADDR_CTRL;
    hit_evt  = i_req.addr == `HDC_ADDR_EVT;
    acc_ok   = i_req.valid & i_req.priv & (hit_ctrl | hit_evt);
    // sub-word writes have no defined effect, so they are dropped
    wr_ok    = acc_ok & i_req.write & i_req.word;
    key_ok   = i_req.wdata[`HDC_KEY_HI:`HDC_KEY_LO] == `HDC_KEY;
    ctrl_wr  = wr_ok & hit_ctrl & key_ok;
    evt_wr   = wr_ok & hit_evt;
    ctrl_rd  = acc_ok & ~i_req.write & hit_ctrl;
  end

  // ----------------------------------------------------------------
  // debug event status flags
  // ----------------------------------------------------------------
  logic [`HDC_EVT_W-1:0] evt_set;  // hardware events this cycle
  logic [`HDC_EVT_W-1:0] evt_clr;  // write-one-to-clear mask
  logic [`HDC_EVT_W-1:0] evt_q;    // flag values

  always_comb begin
    evt_set = '0;
    evt_set[`HDC_EVT_EXT] = i_evt.ext;
    // absent units leave their flag stuck at zero
    evt_set[`HDC_EVT_VC]  = i_evt.vector_catch_flag & HAS_HALT_DEBUG;
    evt_set[`HDC_EVT_WP]  = i_evt.watch & HAS_WATCH_UNIT;
    evt_set[`HDC_EVT_BP]  = i_evt.breakpoint_flag;
    evt_set[`HDC_EVT_HS]  = i_evt.halt_step;
    evt_clr = evt_wr ? i_req.wdata[`HDC_EVT_W-1:0] : '0;
  end

  hdc_sticky #(
    .W   (`HDC_EVT_W),
    .RST (`HDC_EVT_RST)
  ) u_evt (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_set   (evt_set),
    .i_clr   (evt_clr),
    .o_q     (evt_q)
  );

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  logic en_reg,   en_next;     // debug enable
  logic halt_reg, halt_next;   // halt request
  logic step_reg, step_next;   // single step
  logic mask_reg, mask_next;   // interrupt mask
  logic snap_reg, snap_next;   // snap stall
  logic sde_reg, sde_next;     // secure debug status, also gates snap stall writes
  logic clr_req;               // request to clear the halt control
  logic w_en, w_halt;          // values the write leaves behind

  always_comb begin
    en_next   = en_reg;
    halt_next = halt_reg;
    step_next = step_reg;
    mask_next = mask_reg;
    snap_next = snap_reg;
    w_en      = en_reg;
    w_halt    = i_req.wdata[`HDC_C_HALT];
    if (ctrl_wr) begin
      // software cannot flip the enable; only the debugger can
      if (i_req.debugger) begin
        en_next = i_req.wdata[`HDC_C_EN];
        w_en    = i_req.wdata[`HDC_C_EN];
      end
      halt_next = w_halt;
      step_next = i_req.wdata[`HDC_C_STEP];
      mask_next = i_req.wdata[`HDC_C_MASK];
      // snap stall is held only when the same write arms halt too
      if (sde_reg) begin
        snap_next = i_req.wdata[`HDC_C_SNAP] & w_en & w_halt;
      end
    end
    if (i_ext_restart) begin
      halt_next = 1'b0;
    end
    // a pending debug entry re-arms halt even over a clear
    if (i_dbg_pend) begin
      halt_next = 1'b1;
    end else if (i_warm_rst) begin
      halt_next = 1'b0;
    end
    clr_req = (ctrl_wr & halt_reg & ~w_halt) | i_ext_restart;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_reg   <= 1'b0;
      halt_reg <= 1'b0;
      step_reg <= 1'b0;
      mask_reg <= 1'b0;
      snap_reg <= 1'b0;
    end else begin
      en_reg   <= en_next;
      halt_reg <= halt_next;
      step_reg <= step_next;
      mask_reg <= mask_next;
      snap_reg <= snap_next;
    end
  end

  // ----------------------------------------------------------------
  // read-clear stickies: restart, reset, retire
  // ----------------------------------------------------------------
  logic [`HDC_STK_W-1:0] stk_set;  // hardware sets
  logic [`HDC_STK_W-1:0] stk_clr;  // cleared by a read
  logic [`HDC_STK_W-1:0] stk_q;    // sticky values

  always_comb begin
    stk_set = '0;
    stk_set[`HDC_STK_RESTART] = clr_req;
    stk_set[`HDC_STK_RESET]   = i_warm_rst;
    stk_set[`HDC_STK_RETIRE]  = i_retire;
    stk_clr = ctrl_rd ? '1 : '0;
  end

  // cold reset starts with reset-sticky high, a cold reset is a reset too
  hdc_sticky #(
    .W   (`HDC_STK_W),
    .RST (`HDC_STK_RST)
  ) u_stk (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_set   (stk_set),
    .i_clr   (stk_clr),
    .o_q     (stk_q)
  );

  // ----------------------------------------------------------------
  // secure debug status and register ready
  // ----------------------------------------------------------------
  logic hlt_reg, hlt_next;     // halted seen last cycle
  logic rdy_reg, rdy_next;     // transfer ready

  always_comb begin
    hlt_next = i_core.halted;
    if (!i_core.halted) begin
      sde_next = i_core.sec_allowed;
    end else if (!hlt_reg) begin
      // entry cycle: latch from the state the core came from
      sde_next = i_core.in_secure | i_core.sec_allowed;
    end else begin
      sde_next = sde_reg;
    end
    // a selector write beats a done arriving in the same cycle
    rdy_next = rdy_reg;
    if (i_xfer_done) begin
      rdy_next = 1'b1;
    end
    if (i_xfer_sel_wr) begin
      rdy_next = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sde_reg <= 1'b0;
      hlt_reg <= 1'b0;
      rdy_reg <= `HDC_RDY_RST;
    end else begin
      sde_reg <= sde_next;
      hlt_reg <= hlt_next;
      rdy_reg <= rdy_next;
    end
  end

  // ----------------------------------------------------------------
  // read data, answer and effective controls
  // ----------------------------------------------------------------
  hdc_rsp_t  rsp_reg, rsp_next;    // bus answer
  hdc_ctrl_t ctl_reg, ctl_next;    // controls to the core
  logic      gate;                 // debug enabled and allowed
  logic      sec_blk;              // secure core, secure debug off

  always_comb begin
    rsp_next       = '0;
    rsp_next.ack   = i_req.valid;
    // unprivileged access to a mapped register is a bus fault
    rsp_next.fault = i_req.valid & ~i_req.priv & (hit_ctrl | hit_evt);
    if (acc_ok & ~i_req.write & hit_evt) begin
      rsp_next.rdata[`HDC_EVT_W-1:0] = evt_q;
    end
    if (ctrl_rd) begin
      rsp_next.rdata[`HDC_ST_RESTART] = stk_q[`HDC_STK_RESTART];
      rsp_next.rdata[`HDC_ST_RESET]   = stk_q[`HDC_STK_RESET];
      rsp_next.rdata[`HDC_ST_RETIRE]  = stk_q[`HDC_STK_RETIRE];
      rsp_next.rdata[`HDC_ST_SDE]     = sde_reg;
      // lockup is hidden from software and gone once halted
      rsp_next.rdata[`HDC_ST_LOCKUP]  = i_core.lockup & ~i_core.halted
                                        & i_req.debugger;
      rsp_next.rdata[`HDC_ST_SLEEP]   = i_core.sleeping;
      rsp_next.rdata[`HDC_ST_HALT]    = i_core.halted;
      rsp_next.rdata[`HDC_ST_RDY]     = rdy_reg;
      rsp_next.rdata[`HDC_C_SNAP]     = snap_reg;
      rsp_next.rdata[`HDC_C_MASK]     = mask_reg;
      rsp_next.rdata[`HDC_C_STEP]     = step_reg;
      rsp_next.rdata[`HDC_C_HALT]     = halt_reg;
      rsp_next.rdata[`HDC_C_EN]       = en_reg;
    end
    gate    = en_reg & i_core.halt_allowed;
    sec_blk = i_core.in_secure & ~sde_reg;
    ctl_next             = '0;
    ctl_next.halt        = halt_reg & gate & ~sec_blk;
    ctl_next.step        = step_reg & gate & ~sec_blk;
    ctl_next.mask        = mask_reg & gate;
    // secure-targeted interrupts stay live without secure debug
    ctl_next.mask_secure = mask_reg & gate & sde_reg;
    ctl_next.snap        = snap_reg & gate;
    ctl_next.restart     = clr_req;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rsp_reg <= '0;
      ctl_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
      ctl_reg <= ctl_next;
    end
  end

  assign o_rsp  = rsp_reg;
  assign o_ctrl = ctl_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // a write with a wrong key leaves every control alone
  a_key_guard: assert property (
    (i_req.valid & i_req.write & hit_ctrl & ~key_ok & ~i_dbg_pend
     & ~i_warm_rst & ~i_ext_restart)
    |=> $stable({en_reg, step_reg, mask_reg, snap_reg, halt_reg}))
    else $error("control changed on a write without the key");
  // a processed halt clear shows as restart sticky next cycle
  a_restart_set: assert property (
    clr_req |=> stk_q[`HDC_STK_RESTART] && o_ctrl.restart) else $error("restart sticky not set after halt clear");
  // clear and set together: halt stays armed, restart reported
  a_rehalt_both: assert property (
    (i_ext_restart & i_dbg_pend) |=> halt_reg && stk_q[`HDC_STK_RESTART])
    else $error("coincident clear and set lost the halt");
  // the external event beats a coincident write-one-to-clear
  a_evt_set_wins: assert property (
    (i_evt.ext & evt_clr[`HDC_EVT_EXT]) |=> evt_q[`HDC_EVT_EXT]) else $error("external event lost against a clear");
  // warm reset with no pending entry drops halt and marks reset
  a_warm_clear: assert property (
    (i_warm_rst & ~i_dbg_pend) |=> !halt_reg && stk_q[`HDC_STK_RESET]) else $error("warm reset did not clear halt");
  // a read with no retire clears the retire sticky
  a_retire_rdclr: assert property (
    (ctrl_rd & ~i_retire) |=> !stk_q[`HDC_STK_RETIRE]) else $error("retire sticky survived a read");
  // ready is still low two cycles after a selector write when no done arrives in between
  sequence s_sel_wr;
    i_xfer_sel_wr ##1 !i_xfer_done [*2];
  endsequence
  a_rdy_drop: assert property (
    s_sel_wr |-> !rdy_reg) else $error("ready rose without a finished transfer");
  // with debug disabled no halt or step reaches the core
  a_gate_off: assert property (
    !en_reg |=> !o_ctrl.halt && !o_ctrl.step && !o_ctrl.mask) else $error("control active with debug disabled");
  // unprivileged control register access answers with a fault
  a_unpriv_fault: assert property (
    (i_req.valid & ~i_req.priv & hit_ctrl) |=> o_rsp.ack && o_rsp.fault)
    else $error("unprivileged access not faulted");
  // secure status does not move while the core stays halted
  a_sde_hold: assert property (
    (i_core.halted & hlt_reg) |=> $stable(sde_reg)) else $error("secure status changed while halted");
  // software never sees lockup
  a_lockup_hide: assert property (
    (ctrl_rd & ~i_req.debugger) |=> !o_rsp.rdata[`HDC_ST_LOCKUP]) else $error("lockup shown to software");
endmodule // hdc_top

// [sim/hdc_dbg_model.sv]
`timescale 1ns/1ns
`include "hdc_params.svh"
// --------------------------------------------------------------
// debugger model: one register access at a time on the access port
// --------------------------------------------------------------
module hdc_dbg_model (
  // clock
  input  wire logic              i_clock,
  // access requests towards the device
  output hdc_pkg::hdc_req_t      o_req,
  // device answer and core state
  input  wire hdc_pkg::hdc_rsp_t i_rsp,
  input  wire logic              i_halted
);
  import hdc_pkg::*;
  logic en_sh   = 1'b0;  // enable as last written by us
  logic mask_sh = 1'b0;  // interrupt mask as last written by us
  logic word_sh = 1'b1;  // full-word access unless a test asks for a narrower one
  initial o_req = '0;
  // drive one access, hold it to the taking edge, take the answer after it
  task automatic acc(input logic wr, pr, dbg, input logic [31:0] a, wd, output hdc_rsp_t r);
    logic [31:0] d;
    hdc_req_t    t;
    d = wd;
    if (wr && dbg && a == `HDC_ADDR_CTRL && d[31:16] == `HDC_KEY) begin
      if (!en_sh && d[0]) d[3] = 1'b0;
      if (!d[1] && d[3] != mask_sh) d[3] = mask_sh;
      if (i_halted) d[5] = 1'b0;
      en_sh = d[0];
      mask_sh = d[3];
    end
    @(posedge i_clock);
    #1;
    o_req = '{valid: 1'b1, write: wr, priv: pr, debugger: dbg, word: word_sh, addr: a, wdata: d};
    @(posedge i_clock);
    #1;
    r = i_rsp;
    // released lines show the inverse, never the old value
    t = ~o_req;
    t.valid = 1'b0;
    o_req = t;
  endtask
endmodule // hdc_dbg_model

// [sim/tb_hdc_top.sv]
`timescale 1ns/1ns
`include "hdc_params.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_hdc_top;
  import hdc_pkg::*;
  // --------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------
  logic      i_clock, i_rst_b, warm, pend, xrst, retire, xsel, xdone;
  hdc_req_t  req;
  hdc_rsp_t  rsp, r;
  hdc_core_t core;
  hdc_evt_t  evt;
  hdc_ctrl_t ctrl;
  int        failures = 0;
  int        checks = 0;
  int        restarts = 0;
  localparam logic [31:0] C = `HDC_ADDR_CTRL;
  localparam logic [31:0] E = `HDC_ADDR_EVT;

  hdc_top hdc_top_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_req(req), .o_rsp(rsp), .i_core(core),
    .i_evt(evt), .i_warm_rst(warm), .i_dbg_pend(pend), .i_ext_restart(xrst), .i_retire(retire),
    .i_xfer_sel_wr(xsel), .i_xfer_done(xdone), .o_ctrl(ctrl));
  hdc_dbg_model hdc_dbg_model_inst (.i_clock(i_clock), .o_req(req), .i_rsp(rsp), .i_halted(core.halted));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // restart stands one cycle, so count it once at the falling edge where it is settled
  always @(negedge i_clock) if (ctrl.restart === 1'b1) restarts++;

  // --------------------------------------------------------------
  // access helpers
  // --------------------------------------------------------------
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, d);
    hdc_dbg_model_inst.acc(1'b1, 1'b1, 1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic dbg, input logic [31:0] m, e, input string n);
    hdc_dbg_model_inst.acc(1'b0, 1'b1, dbg, a, 32'h0, r);
    `CHK(n, e, r.rdata & m)
  endtask
  task automatic end_sim();
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 110 cycles the run needs
  initial begin
    #200000;
    failures++;
    end_sim();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    {warm, pend, xrst, retire, xsel, xdone} = '0;
    evt = '0;
    core = '{halted: 1'b0, in_secure: 1'b0, sec_allowed: 1'b0, halt_allowed: 1'b1, lockup: 1'b0, sleeping: 1'b0};
    repeat (2) @(posedge i_clock);
    #1;
    i_rst_b = 1'b1;
    rdc(C, 1'b1, 32'hFFFF_0000, 32'h0201_0000, "status after reset");
    rdc(C, 1'b1, 32'hFFFF_0000, 32'h0001_0000, "status read clear");
    hdc_dbg_model_inst.acc(1'b0, 1'b0, 1'b1, C, 32'h0, r);
    `CHK("unprivileged fault", 1'b1, r.fault)
    `CHK("unprivileged ack", 1'b1, r.ack)
    rdc(32'hE000_EE00, 1'b1, 32'hFFFF_FFFF, 32'h0, "unmapped");
    // each event flag sets alone and clears by writing one
    for (int i = 0; i < 5; i++) begin
      evt = hdc_evt_t'(5'h01 << i);
      tick();
      evt = '0;
      rdc(E, 1'b1, 32'hFFFF_FFFF, 32'h1 << i, "event flag");
      wr(E, 32'h1 << i);
      rdc(E, 1'b1, 32'hFFFF_FFFF, 32'h0, "event w1c");
    end
    hdc_dbg_model_inst.acc(1'b1, 1'b1, 1'b0, C, 32'hA05F_0003, r);
    rdc(C, 1'b1, 32'h1, 32'h0, "software enable");
    wr(C, 32'h1234_0003);
    rdc(C, 1'b1, 32'h1, 32'h0, "bad key");
    wr(C, 32'hA05F_0003);
    rdc(C, 1'b1, 32'h3F, 32'h03, "good key");
    `CHK("halt out", 1'b1, ctrl.halt)
    core.halted = 1'b1;
    wr(C, 32'hA05F_0001);
    rdc(C, 1'b1, 32'h0400_0002, 32'h0400_0000, "restart sticky");
    `CHK("restart pulses", 1, restarts)
    wr(C, 32'hA05F_0003);
    {xrst, pend} = 2'b11;
    tick();
    {xrst, pend} = 2'b00;
    rdc(C, 1'b1, 32'h0400_0002, 32'h0400_0002, "clear with set");
    wr(C, 32'hA05F_000B);
    tick();
    `CHK("mask out", 1'b1, ctrl.mask)
    `CHK("mask secure", 1'b0, ctrl.mask_secure)
    wr(C, 32'hA05F_0003);
    core.halt_allowed = 1'b0;
    wr(C, 32'hA05F_0007);
    tick();
    `CHK("step gated", 1'b0, ctrl.step)
    `CHK("halt gated", 1'b0, ctrl.halt)
    core.halt_allowed = 1'b1;
    tick();
    tick();
    `CHK("step out", 1'b1, ctrl.step)
    xsel = 1'b1;
    tick();
    xsel = 1'b0;
    rdc(C, 1'b1, 32'h0001_0000, 32'h0, "ready low");
    xdone = 1'b1;
    tick();
    xdone = 1'b0;
    rdc(C, 1'b1, 32'h0001_0000, 32'h0001_0000, "ready high");
    core = '{halted: 1'b0, in_secure: 1'b0, sec_allowed: 1'b1, halt_allowed: 1'b1, lockup: 1'b1, sleeping: 1'b1};
    tick();
    rdc(C, 1'b1, 32'h001E_0000, 32'h001C_0000, "running status");
    rdc(C, 1'b0, 32'h001E_0000, 32'h0014_0000, "software lockup");
    core.halted = 1'b1;
    tick();
    tick();
    core.sec_allowed = 1'b0;
    tick();
    rdc(C, 1'b1, 32'h001E_0000, 32'h0016_0000, "halted status");
    core = '{halted: 1'b0, in_secure: 1'b0, sec_allowed: 1'b1, halt_allowed: 1'b1, lockup: 1'b0, sleeping: 1'b0};
    tick();
    wr(C, 32'hA05F_0023);
    tick();
    `CHK("snap out", 1'b1, ctrl.snap)
    retire = 1'b1;
    tick();
    retire = 1'b0;
    rdc(C, 1'b1, 32'h0100_0000, 32'h0100_0000, "retire sticky");
    warm = 1'b1;
    tick();
    warm = 1'b0;
    rdc(C, 1'b1, 32'h0200_0002, 32'h0200_0000, "warm reset");
    // a keyed write that is not full-word must leave the controls alone
    hdc_dbg_model_inst.word_sh = 1'b0;
    wr(C, 32'hA05F_0007);
    hdc_dbg_model_inst.word_sh = 1'b1;
    rdc(C, 1'b1, 32'h3F, 32'h21, "sub-word write");
    // a cold reset in mid-run drops every event flag and every control
    evt = '1;
    tick();
    evt = '0;
    i_rst_b = 1'b0;
    tick();
    i_rst_b = 1'b1;
    rdc(E, 1'b1, 32'hFFFF_FFFF, 32'h0, "cold reset flags");
    rdc(C, 1'b1, 32'h0700_003F, 32'h0200_0000, "cold reset status");
    end_sim();
  end
endmodule // tb_hdc_top
